// ### logic/bsf_regs.svh
`ifndef BSF_REGS_SVH
`define BSF_REGS_SVH

// register byte offsets
`define CMD_OFFSET      12'h000
`define FLAGS_OFFSET    12'h004
`define STATE_OFFSET    12'h008
`define GPR_BASE        12'h100
`define GPR_LIMIT       12'h180
`define IO_BASE         12'h200
`define IO_LIMIT        12'h300

// command word fields
`define CMD_OP_LSB      0
`define CMD_REG_LSB     5
`define CMD_BIT_LSB     10
`define CMD_IO_LSB      13
`define CMD_WIDTH       19

// status register flag positions
`define FLAG_C          3'd0
`define FLAG_Z          3'd1
`define FLAG_N          3'd2
`define FLAG_V          3'd3
`define FLAG_S          3'd4
`define FLAG_H          3'd5
`define FLAG_T          3'd6
`define FLAG_I          3'd7

// state register fields
`define STATE_BUSY_BIT  0
`define STATE_BAD_BIT   1
`define STATE_SLP_LSB   8

// reset values
`define FLAGS_RESET     8'h00
`define SLEEP_CNT_RESET 8'h00

// execute cycles
`define IO_CLEAR_CYCLES 2
`define SIMPLE_CYCLES   1

// bus responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// ### logic/bsf_pkg.sv
`include "bsf_regs.svh"

package bsf_pkg;

    typedef enum logic [4:0] {
        idle_op                = 5'h00,
        io_bit_clear_op        = 5'h01,
        logic_left_shift_op    = 5'h02,
        logic_right_shift_op   = 5'h03,
        carry_left_rotate_op   = 5'h04,
        carry_right_rotate_op  = 5'h05,
        sign_right_shift_op    = 5'h06,
        nibble_swap_op         = 5'h07,
        generic_flag_set_op    = 5'h08,
        generic_flag_clear_op  = 5'h09,
        reg_bit_to_transfer_op = 5'h0a,
        transfer_to_reg_bit_op = 5'h0b,
        carry_set_op           = 5'h0c,
        carry_clear_op         = 5'h0d,
        negative_set_op        = 5'h0e,
        negative_clear_op      = 5'h0f,
        zero_set_op            = 5'h10,
        zero_clear_op          = 5'h11,
        int_enable_op          = 5'h12,
        int_disable_op         = 5'h13,
        sign_flag_set_op       = 5'h14,
        sign_flag_clear_op     = 5'h15,
        overflow_set_op        = 5'h16,
        overflow_clear_op      = 5'h17,
        transfer_set_op        = 5'h18,
        transfer_clear_op      = 5'h19,
        half_carry_set_op      = 5'h1a,
        half_carry_clear_op    = 5'h1b,
        sleep_op               = 5'h1c
    } op_t;

    typedef struct packed {
        logic [5:0] io_addr;
        logic [2:0] bit_sel;
        logic [4:0] reg_idx;
        op_t        op;
    } cmd_t;

    typedef struct packed {
        logic [7:0] value;
        logic [7:0] flags;
        logic       write_reg;
        logic       write_io;
        logic       bad;
    } alu_out_t;

    typedef enum logic [3:0] {
        st_idle    = 4'b0001,
        st_fetch   = 4'b0010,
        st_exec    = 4'b0100,
        st_io_hold = 4'b1000
    } exec_state_t;

    typedef enum logic [2:0] {
        rd_idle = 3'b001,
        rd_wait = 3'b010,
        rd_resp = 3'b100
    } rd_state_t;

endpackage : bsf_pkg

// ### logic/word_store.sv
module word_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic             re,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_rdata;

    always_comb
    begin
        next_rdata = rdata;
        if (re)
        begin
            next_rdata = mem[raddr];
        end
    end

    // storage has no reset: contents are software's to load
    always_ff @(posedge core_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rdata <= '0;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end
endmodule : word_store

// ### logic/bit_shift_flag_ops.sv
// How it works
// - clear-I/O-bit zeroes one I/O register bit, no flags, two cycles
// - logical left shift, zero into bit 0, updates Z C N V, one cycle
// - logical right shift, zero into bit 7, updates Z C N V, one cycle
// - rotate left through carry, old bit 7 to carry, one cycle
// - rotate right through carry, old bit 0 to carry, one cycle
// - arithmetic right shift keeps sign bit, updates Z C N V, one cycle
// - nibble swap exchanges register halves, no flag change, one cycle
// - bit store copies register bit into transfer flag only, one cycle
// - bit load copies transfer flag into register bit, no flags
// - set half-carry forces H to one, nothing else
// - clear half-carry forces H to zero, nothing else
// - set overflow forces V to one, nothing else
// - clear overflow forces V to zero, nothing else
// - set sign forces S to one, nothing else
// - clear sign forces S to zero, nothing else
// - sleep takes one cycle, no flags, signals the sleep logic
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
module bit_shift_flag_ops (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             sleep_req,
    output bsf_pkg::cmd_t    active_cmd
);
    import bsf_pkg::*;

    // execute core state
    exec_state_t state;
    exec_state_t next_state;
    logic [7:0]  status_register;
    logic [7:0]  next_status_register;
    logic        bad_op;
    logic        next_bad_op;
    logic [7:0]  sleep_count;
    logic [7:0]  next_sleep_count;
    logic        next_sleep_req;
    cmd_t        next_active_cmd;

    // bus write side
    logic        aw_hold;
    logic        next_aw_hold;
    logic [11:0] aw_addr;
    logic [11:0] next_aw_addr;
    logic        w_hold;
    logic        next_w_hold;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic [3:0]  w_strb;
    logic [3:0]  next_w_strb;
    logic        next_bvalid;
    logic [1:0]  next_bresp;

    // bus read side
    rd_state_t   rd_state;
    rd_state_t   next_rd_state;
    logic [11:0] rd_addr;
    logic [11:0] next_rd_addr;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;

    // memory ports
    logic        gpr_we;
    logic [4:0]  gpr_waddr;
    logic [7:0]  gpr_wdata;
    logic        gpr_re;
    logic [4:0]  gpr_raddr;
    logic [7:0]  gpr_rdata;
    logic        io_we;
    logic [5:0]  io_waddr;
    logic [7:0]  io_wdata;
    logic        io_re;
    logic [5:0]  io_raddr;
    logic [7:0]  io_rdata;

    logic        wr_go;
    logic        exec_idle;
    alu_out_t    alu;

    word_store #(.WIDTH(8), .DEPTH(32)) u_gpr (
        .core_clk (core_clk),
        .reset    (reset),
        .we       (gpr_we),
        .waddr    (gpr_waddr),
        .wdata    (gpr_wdata),
        .re       (gpr_re),
        .raddr    (gpr_raddr),
        .rdata    (gpr_rdata)
    );

    word_store #(.WIDTH(8), .DEPTH(64)) u_io (
        .core_clk (core_clk),
        .reset    (reset),
        .we       (io_we),
        .waddr    (io_waddr),
        .wdata    (io_wdata),
        .re       (io_re),
        .raddr    (io_raddr),
        .rdata    (io_rdata)
    );

    function automatic logic in_range(input logic [11:0] a,
                                      input logic [11:0] lo,
                                      input logic [11:0] hi);
        in_range = (a >= lo) && (a < hi);
    endfunction : in_range

    // result and flag image of one operation; operand is register or I/O
    function automatic alu_out_t compute(input cmd_t c,
                                         input logic [7:0] gv,
                                         input logic [7:0] iv,
                                         input logic [7:0] f);
        alu_out_t o;
        logic     cy;
        o = '{value: gv, flags: f, write_reg: 1'b0, write_io: 1'b0,
               bad: 1'b0};
        cy = 1'b0;
        unique case (c.op)
            io_bit_clear_op:
            begin
                o.value = iv;
                o.value[c.bit_sel] = 1'b0;
                o.write_io = 1'b1;
            end
            logic_left_shift_op:
            begin
                o.value = {gv[6:0], 1'b0};
                cy = gv[7];
            end
            logic_right_shift_op:
            begin
                o.value = {1'b0, gv[7:1]};
                cy = gv[0];
            end
            carry_left_rotate_op:
            begin
                o.value = {gv[6:0], f[`FLAG_C]};
                cy = gv[7];
            end
            carry_right_rotate_op:
            begin
                o.value = {f[`FLAG_C], gv[7:1]};
                cy = gv[0];
            end
            sign_right_shift_op:
            begin
                o.value = {gv[7], gv[7:1]};
                cy = gv[0];
            end
            nibble_swap_op:
            begin
                o.value = {gv[3:0], gv[7:4]};
            end
            reg_bit_to_transfer_op:
            begin
                o.flags[`FLAG_T] = gv[c.bit_sel];
            end
            transfer_to_reg_bit_op:
            begin
                o.value[c.bit_sel] = f[`FLAG_T];
            end
            generic_flag_set_op:   o.flags[c.bit_sel] = 1'b1;
            generic_flag_clear_op: o.flags[c.bit_sel] = 1'b0;
            carry_set_op:          o.flags[`FLAG_C] = 1'b1;
            carry_clear_op:        o.flags[`FLAG_C] = 1'b0;
            negative_set_op:       o.flags[`FLAG_N] = 1'b1;
            negative_clear_op:     o.flags[`FLAG_N] = 1'b0;
            zero_set_op:           o.flags[`FLAG_Z] = 1'b1;
            zero_clear_op:         o.flags[`FLAG_Z] = 1'b0;
            int_enable_op:         o.flags[`FLAG_I] = 1'b1;
            int_disable_op:        o.flags[`FLAG_I] = 1'b0;
            transfer_set_op:       o.flags[`FLAG_T] = 1'b1;
            transfer_clear_op:     o.flags[`FLAG_T] = 1'b0;
            half_carry_set_op:     o.flags[`FLAG_H] = 1'b1;
            half_carry_clear_op:   o.flags[`FLAG_H] = 1'b0;
            overflow_set_op:       o.flags[`FLAG_V] = 1'b1;
            overflow_clear_op:     o.flags[`FLAG_V] = 1'b0;
            sign_flag_set_op:      o.flags[`FLAG_S] = 1'b1;
            sign_flag_clear_op:    o.flags[`FLAG_S] = 1'b0;
            idle_op, sleep_op:     o.bad = 1'b0;
            default:               o.bad = 1'b1;
        endcase
        if (c.op inside {logic_left_shift_op, logic_right_shift_op,
                         carry_left_rotate_op, carry_right_rotate_op,
                         sign_right_shift_op})
        begin
            // S and H are left alone: only Z C N V follow a shift
            o.flags[`FLAG_C] = cy;
            o.flags[`FLAG_Z] = (o.value == 8'h00);
            o.flags[`FLAG_N] = o.value[7];
            o.flags[`FLAG_V] = o.value[7] ^ cy;
        end
        if (c.op inside {logic_left_shift_op, logic_right_shift_op,
                         carry_left_rotate_op, carry_right_rotate_op,
                         sign_right_shift_op, nibble_swap_op,
                         transfer_to_reg_bit_op})
        begin
            o.write_reg = 1'b1;
        end
        return o;
    endfunction : compute

    assign exec_idle     = (state == st_idle);
    assign wr_go         = aw_hold && w_hold && !s_axi_bvalid && exec_idle
                           && (rd_state == rd_idle);
    assign s_axi_awready = !aw_hold && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold && !s_axi_bvalid;
    assign s_axi_arready = (rd_state == rd_idle) && exec_idle;
    assign alu           = compute(active_cmd, gpr_rdata, io_rdata,
                                   status_register);

    // memory port steering: execution owns the ports outside idle
    always_comb
    begin
        gpr_we    = 1'b0;
        gpr_waddr = aw_addr[6:2];
        gpr_wdata = w_data[7:0];
        io_we     = 1'b0;
        io_waddr  = aw_addr[7:2];
        io_wdata  = w_data[7:0];
        gpr_re    = 1'b0;
        gpr_raddr = s_axi_araddr[6:2];
        io_re     = 1'b0;
        io_raddr  = s_axi_araddr[7:2];
        if (state == st_fetch)
        begin
            gpr_re    = 1'b1;
            gpr_raddr = active_cmd.reg_idx;
            io_re     = 1'b1;
            io_raddr  = active_cmd.io_addr;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            gpr_re = in_range(s_axi_araddr, `GPR_BASE, `GPR_LIMIT);
            io_re  = in_range(s_axi_araddr, `IO_BASE, `IO_LIMIT);
        end
        if (state == st_exec)
        begin
            gpr_we    = alu.write_reg;
            gpr_waddr = active_cmd.reg_idx;
            gpr_wdata = alu.value;
            io_we     = alu.write_io;
            io_waddr  = active_cmd.io_addr;
            io_wdata  = alu.value;
        end
        else if (wr_go && w_strb[0])
        begin
            gpr_we = in_range(aw_addr, `GPR_BASE, `GPR_LIMIT);
            io_we  = in_range(aw_addr, `IO_BASE, `IO_LIMIT);
        end
    end

    // execute sequencer and bus write handling
    always_comb
    begin
        next_state           = state;
        next_status_register = status_register;
        next_bad_op          = bad_op;
        next_sleep_count     = sleep_count;
        next_sleep_req       = 1'b0;
        next_active_cmd      = active_cmd;
        next_aw_hold         = aw_hold;
        next_aw_addr         = aw_addr;
        next_w_hold          = w_hold;
        next_w_data          = w_data;
        next_w_strb          = w_strb;
        next_bvalid          = s_axi_bvalid;
        next_bresp           = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_hold = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_hold = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        unique case (state)
            st_idle:
            begin
                if (wr_go)
                begin
                    next_aw_hold = 1'b0;
                    next_w_hold  = 1'b0;
                    next_bvalid  = 1'b1;
                    next_bresp   = `RESP_OKAY;
                    if (aw_addr == `CMD_OFFSET)
                    begin
                        // a partial command word would launch garbage
                        if (w_strb[2:0] == 3'b111)
                        begin
                            next_active_cmd = cmd_t'(w_data[`CMD_WIDTH-1:0]);
                            next_bad_op     = 1'b0;
                            next_state      = st_fetch;
                        end
                    end
                    else if (aw_addr == `FLAGS_OFFSET)
                    begin
                        if (w_strb[0])
                        begin
                            next_status_register = w_data[7:0];
                        end
                    end
                    else if (aw_addr == `STATE_OFFSET)
                    begin
                        next_bresp = `RESP_OKAY;
                    end
                    else if (!in_range(aw_addr, `GPR_BASE, `GPR_LIMIT)
                             && !in_range(aw_addr, `IO_BASE, `IO_LIMIT))
                    begin
                        next_bresp = `RESP_SLVERR;
                    end
                end
            end
            st_fetch:
            begin
                next_state = st_exec;
            end
            st_exec:
            begin
                // one execute cycle: flags and register land together
                next_status_register = alu.flags;
                next_bad_op          = alu.bad;
                if (active_cmd.op == sleep_op)
                begin
                    next_sleep_req   = 1'b1;
                    next_sleep_count = sleep_count + 8'h01;
                end
                if (alu.write_io)
                begin
                    next_state = st_io_hold;
                end
                else
                begin
                    next_state = st_idle;
                end
            end
            st_io_hold:
            begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state           <= st_idle;
            status_register <= `FLAGS_RESET;
            bad_op          <= 1'b0;
            sleep_count     <= `SLEEP_CNT_RESET;
            sleep_req       <= 1'b0;
            active_cmd      <= '0;
            aw_hold         <= 1'b0;
            aw_addr         <= 12'h000;
            w_hold          <= 1'b0;
            w_data          <= 32'h0000_0000;
            w_strb          <= 4'h0;
            s_axi_bvalid    <= 1'b0;
            s_axi_bresp     <= `RESP_OKAY;
        end
        else
        begin
            state           <= next_state;
            status_register <= next_status_register;
            bad_op          <= next_bad_op;
            sleep_count     <= next_sleep_count;
            sleep_req       <= next_sleep_req;
            active_cmd      <= next_active_cmd;
            aw_hold         <= next_aw_hold;
            aw_addr         <= next_aw_addr;
            w_hold          <= next_w_hold;
            w_data          <= next_w_data;
            w_strb          <= next_w_strb;
            s_axi_bvalid    <= next_bvalid;
            s_axi_bresp     <= next_bresp;
        end
    end

    // bus read: address taken, memory word arrives, answer held
    always_comb
    begin
        next_rd_state = rd_state;
        next_rd_addr  = rd_addr;
        next_rdata    = s_axi_rdata;
        next_rresp    = s_axi_rresp;
        unique case (rd_state)
            rd_idle:
            begin
                if (s_axi_arvalid && s_axi_arready)
                begin
                    next_rd_addr  = s_axi_araddr;
                    next_rd_state = rd_wait;
                end
            end
            rd_wait:
            begin
                next_rdata    = 32'h0000_0000;
                next_rresp    = `RESP_OKAY;
                next_rd_state = rd_resp;
                if (rd_addr == `FLAGS_OFFSET)
                begin
                    next_rdata[7:0] = status_register;
                end
                else if (rd_addr == `STATE_OFFSET)
                begin
                    next_rdata[`STATE_BUSY_BIT] = !exec_idle;
                    next_rdata[`STATE_BAD_BIT]  = bad_op;
                    next_rdata[`STATE_SLP_LSB +: 8] = sleep_count;
                end
                else if (rd_addr == `CMD_OFFSET)
                begin
                    next_rdata[`CMD_WIDTH-1:0] = active_cmd;
                end
                else if (in_range(rd_addr, `GPR_BASE, `GPR_LIMIT))
                begin
                    next_rdata[7:0] = gpr_rdata;
                end
                else if (in_range(rd_addr, `IO_BASE, `IO_LIMIT))
                begin
                    next_rdata[7:0] = io_rdata;
                end
                else
                begin
                    next_rresp = `RESP_SLVERR;
                end
            end
            rd_resp:
            begin
                if (s_axi_rready)
                begin
                    next_rd_state = rd_idle;
                end
            end
        endcase
    end

    assign s_axi_rvalid = (rd_state == rd_resp);

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rd_state    <= rd_idle;
            rd_addr     <= 12'h000;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end
        else
        begin
            rd_state    <= next_rd_state;
            rd_addr     <= next_rd_addr;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end
endmodule : bit_shift_flag_ops

// ### dv/bsf_monitor.sv
module bsf_monitor
    import bsf_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        sleep_req,
    input wire cmd_t        active_cmd
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("bvalid stayed after bready");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("rvalid stayed after rready");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready
        |-> !s_axi_rvalid ##2 s_axi_rvalid) else $error("read late");
    a_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during open read");
    a_write_blocks: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready during open write");
    a_sleep_pulse: assert property (sleep_req |=> !sleep_req)
        else $error("sleep pulse too long");
    a_sleep_cause: assert property (sleep_req |->
        active_cmd.op == sleep_op) else $error("sleep without op");
    a_err_zero: assert property (s_axi_rvalid && s_axi_rresp != 2'b00
        |-> s_axi_rdata == 32'h0) else $error("error read not zero");
    c_sleep: cover property (sleep_req);
    c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
    c_wr_done: cover property (s_axi_bvalid && s_axi_bready);
endmodule : bsf_monitor

// ### dv/sleep_model.sv
module sleep_model (
    input wire logic   core_clk,
    input wire logic   reset,
    input wire logic   sleep_req,
    output logic [31:0] sleeps
);
    timeunit 1ns;
    timeprecision 1ns;
    // counts sleep entries handed over by the core
    always_ff @(posedge core_clk or posedge reset)
        if (reset) sleeps <= 32'h0;
        else if (sleep_req) sleeps <= sleeps + 32'h1;
endmodule : sleep_model

// ### dv/tb.sv
`include "bsf_regs.svh"
bind bit_shift_flag_ops bsf_monitor bsf_monitor_i (.*);
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bsf_pkg::*;
    logic        core_clk = 1'b0, reset = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, sleeps, d;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
    logic        s_axi_rready = 1'b1, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, sleep_req;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, lb, lr;
    cmd_t        active_cmd;
    int          bad_count = 0, tests_run = 0;
    byte         fb [8] = '{`FLAG_C, `FLAG_N, `FLAG_Z, `FLAG_I,
                            `FLAG_S, `FLAG_V, `FLAG_T, `FLAG_H};
    always #25 core_clk = ~core_clk;
    bit_shift_flag_ops bit_shift_flag_ops_i (.*);
    sleep_model sleep_model_i (.*);
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // masters both handshakes; ready is snapshotted mid-cycle
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic ha, hw, hb;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        hb = 1'b0;
        for (int n = 0; n < 200 && !hb; n++)
        begin
            @(negedge core_clk);
            ha = s_axi_awready & s_axi_awvalid;
            hw = s_axi_wready & s_axi_wvalid;
            hb = s_axi_bvalid;
            lb = s_axi_bresp;
            @(posedge core_clk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
        end
        if (!hb)
        begin
            bad_count++;
            report_and_stop;
        end
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        logic ha, hr;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        hr = 1'b0;
        for (int n = 0; n < 200 && !hr; n++)
        begin
            @(negedge core_clk);
            ha = s_axi_arready & s_axi_arvalid;
            hr = s_axi_rvalid;
            v = s_axi_rdata;
            lr = s_axi_rresp;
            @(posedge core_clk);
            if (ha) s_axi_arvalid <= 1'b0;
        end
        if (!hr)
        begin
            bad_count++;
            report_and_stop;
        end
    endtask : rd
    task automatic run(input op_t op, input logic [2:0] b,
                       input logic [7:0] r, f, er, ef);
        wr(`FLAGS_OFFSET, {24'h0, f});
        wr(12'h104, {24'h0, r});
        wr(`CMD_OFFSET, {13'h0, 6'h05, b, 5'd1, op});
        rd(12'h104, d);
        chk(d, {24'h0, er});
        rd(`FLAGS_OFFSET, d);
        chk(d, {24'h0, ef});
        $display("test op %h done", op);
    endtask : run
    initial
    begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rd(`FLAGS_OFFSET, d);
        chk(d, 32'h0);
        run(logic_left_shift_op, 0, 8'h81, 8'h30, 8'h02, 8'h39);
        run(logic_right_shift_op, 0, 8'h01, 8'h0, 8'h0, 8'h0b);
        run(carry_left_rotate_op, 0, 8'h80, 8'h1, 8'h1, 8'h9);
        run(carry_right_rotate_op, 0, 8'h1, 8'h1, 8'h80, 8'h5);
        run(sign_right_shift_op, 0, 8'h81, 8'h0, 8'hc0, 8'h5);
        run(nibble_swap_op, 0, 8'h3c, 8'ha5, 8'hc3, 8'ha5);
        run(reg_bit_to_transfer_op, 7, 8'h80, 8'h0, 8'h80, 8'h40);
        run(transfer_to_reg_bit_op, 2, 8'h0, 8'h40, 8'h4, 8'h40);
        run(idle_op, 0, 8'h5a, 8'h96, 8'h5a, 8'h96);
        run(sleep_op, 0, 8'h5a, 8'h69, 8'h5a, 8'h69);
        chk(sleeps, 32'h1);
        run(op_t'(5'h1d), 0, 8'h5a, 8'h96, 8'h5a, 8'h96);
        rd(`STATE_OFFSET, d);
        chk(d, 32'h102);
        for (int i = 0; i < 8; i++)
        begin
            run(op_t'(5'(12 + 2 * i)), 0, 8'h5a, 8'h0, 8'h5a,
                8'h1 << fb[i]);
            run(op_t'(5'(13 + 2 * i)), 0, 8'h5a, 8'hff, 8'h5a,
                ~(8'h1 << fb[i]));
            run(generic_flag_set_op, 3'(i), 8'h5a, 8'h0, 8'h5a,
                8'h1 << i);
            run(generic_flag_clear_op, 3'(i), 8'h5a, 8'hff, 8'h5a,
                ~(8'h1 << i));
        end
        wr(12'h214, 32'hff);
        run(io_bit_clear_op, 3, 8'h5a, 8'h3c, 8'h5a, 8'h3c);
        rd(12'h214, d);
        chk(d, 32'hf7);
        wr(12'h0fc, 32'h1);
        chk({30'h0, lb}, 32'h2);
        rd(12'h0fc, d);
        chk({30'h0, lr} | d, 32'h2);
        report_and_stop;
    end
endmodule : tb
